// ==== wwt_defines.vh ====
`ifndef WWT_DEFINES_VH
`define WWT_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
`define WWT_ADDR_W 8
`define WWT_OFS_CONTROL 8'h00
`define WWT_OFS_STATE 8'h01

// ****************************************************************
// Field layout
// ****************************************************************
`define WWT_CTRL_PERIOD_LSB 0
`define WWT_CTRL_PERIOD_MSB 3
`define WWT_CTRL_WINDOW_LSB 4
`define WWT_CTRL_WINDOW_MSB 7
`define WWT_STATE_LOCK_BIT 7
`define WWT_STATE_PEND_BIT 0
`define WWT_STATE_RESET 8'h00

// ****************************************************************
// Timing in slow ticks
// ****************************************************************
`define WWT_CNT_W 14
`define WWT_CODE_MAX 4'hB
`define WWT_KICK_TICKS 2'h2
`define WWT_SLOW_TICK_HZ 1024

`endif

// ==== wwt_sync.v ====
`timescale 1ns/10ps
module wwt_sync #(
    parameter WIDTH = 1
) (
    clk_sys,
    rst_n,
    asyncIn,
    syncOut
);
    input wire clk_sys;
    input wire rst_n;
    input wire [WIDTH-1:0] asyncIn;
    output wire [WIDTH-1:0] syncOut;

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // ****************************************************************
    // Two-stage synchroniser
    // ****************************************************************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule

// ==== wwt_watchdog.v ====
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "wwt_defines.vh"
module wwt_watchdog (
    clk_sys,
    rst_n,
    regAddr,
    regWrData,
    regWrEn,
    regRdEn,
    regRdData,
    changeGuardOpen,
    fuseWatchdogCfg,
    kickInstruction,
    slowTickIn,
    debugMode,
    cpuHalted,
    sysResetReq,
    sysResetAck,
    crossingPending,
    watchdogActive
);
    input wire clk_sys;
    input wire rst_n;
    input wire [7:0] regAddr;
    input wire [7:0] regWrData;
    input wire regWrEn;
    input wire regRdEn;
    output wire [7:0] regRdData;
    input wire changeGuardOpen;
    input wire [7:0] fuseWatchdogCfg;
    input wire kickInstruction;
    input wire slowTickIn;
    input wire debugMode;
    input wire cpuHalted;
    output wire sysResetReq;
    input wire sysResetAck;
    output wire crossingPending;
    output wire watchdogActive;

    // ****************************************************************
    // Length decode, shared by open and closed fields
    // ****************************************************************
    function [`WWT_CNT_W-1:0] codeTicks;
        input [3:0] code;
        begin
            case (code)
                4'h1: codeTicks = 14'h0008;
                4'h2: codeTicks = 14'h0010;
                4'h3: codeTicks = 14'h0020;
                4'h4: codeTicks = 14'h0040;
                4'h5: codeTicks = 14'h0080;
                4'h6: codeTicks = 14'h0100;
                4'h7: codeTicks = 14'h0200;
                4'h8: codeTicks = 14'h0400;
                4'h9: codeTicks = 14'h0800;
                4'hA: codeTicks = 14'h1000;
                4'hB: codeTicks = 14'h2000;
                default: codeTicks = 14'h0000;
            endcase
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg bootDone_q;
    reg [7:0] ctrl_q;
    reg lock_q;
    reg pending_q;
    reg [7:0] active_q;
    reg tickSeen_q;
    reg kickPend_q;
    reg [1:0] kickAge_q;
    reg [`WWT_CNT_W-1:0] cnt_q;
    reg [`WWT_CNT_W-1:0] cnt_d;
    reg closedPhase_q;
    reg closedPhase_d;
    reg windowLive_q;
    reg windowLive_d;
    reg prevWinOn_q;
    reg resetReq_q;
    reg [7:0] rdData_q;
    reg expire;
    reg badKick;
    wire tickSync;
    wire tickPulse;
    wire ctrlHit;
    wire stateHit;
    wire ctrlWrite;
    wire lockSet;
    wire lockClear;
    wire kickApply;
    wire [3:0] periodCode;
    wire [3:0] windowCode;
    wire [`WWT_CNT_W-1:0] openLen;
    wire [`WWT_CNT_W-1:0] closedLen;
    wire wdOn;
    wire winOn;
    wire running;

    // ****************************************************************
    // Slow tick synchronisation and edge detect
    // ****************************************************************
    // The oscillator is unrelated to clk_sys, so only the second flop is read
    wwt_sync #(
        .WIDTH(1)
    ) u_tickSync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .asyncIn(slowTickIn),
        .syncOut(tickSync)
    );

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tickSeen_q <= 1'b0;
        end
        else
        begin
            tickSeen_q <= tickSync;
        end
    end

    assign tickPulse = tickSync & ~tickSeen_q;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    assign ctrlHit = (regAddr == `WWT_OFS_CONTROL);
    assign stateHit = (regAddr == `WWT_OFS_STATE);
    // Lock only blocks control; an unguarded write is simply dropped
    assign ctrlWrite = regWrEn & ctrlHit & changeGuardOpen & ~lock_q & bootDone_q;
    assign lockSet = regWrEn & stateHit & changeGuardOpen
        & regWrData[`WWT_STATE_LOCK_BIT];
    assign lockClear = regWrEn & stateHit & changeGuardOpen & debugMode
        & ~regWrData[`WWT_STATE_LOCK_BIT];

    // ****************************************************************
    // Control, lock and boot load
    // ****************************************************************
    // Fuse is caught on the first edge after reset release, not in reset
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bootDone_q <= 1'b0;
            ctrl_q <= 8'h00;
            lock_q <= 1'b0;
        end
        else if (!bootDone_q)
        begin
            bootDone_q <= 1'b1;
            ctrl_q <= fuseWatchdogCfg;
            lock_q <= (fuseWatchdogCfg[`WWT_CTRL_PERIOD_MSB:`WWT_CTRL_PERIOD_LSB] != 4'h0);
        end
        else
        begin
            if (ctrlWrite)
            begin
                ctrl_q <= regWrData;
            end
            if (lockSet)
            begin
                lock_q <= 1'b1;
            end
            else if (lockClear)
            begin
                lock_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Crossing of control into the tick domain
    // ****************************************************************
    // A write landing on a tick keeps pending set and moves on the next tick
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pending_q <= 1'b0;
            active_q <= 8'h00;
        end
        else if (!bootDone_q)
        begin
            pending_q <= 1'b0;
            active_q <= fuseWatchdogCfg;
        end
        else if (ctrlWrite)
        begin
            pending_q <= 1'b1;
        end
        else if (pending_q && tickPulse)
        begin
            pending_q <= 1'b0;
            active_q <= ctrl_q;
        end
    end

    assign periodCode = active_q[`WWT_CTRL_PERIOD_MSB:`WWT_CTRL_PERIOD_LSB];
    assign windowCode = active_q[`WWT_CTRL_WINDOW_MSB:`WWT_CTRL_WINDOW_LSB];
    assign openLen = codeTicks(periodCode);
    assign closedLen = codeTicks(windowCode);
    // Reserved period codes decode to zero length and keep the unit off
    assign wdOn = (periodCode != 4'h0) && (openLen != 14'h0000);
    assign winOn = (windowCode != 4'h0) && (closedLen != 14'h0000);
    // No sleep input gates this: counting goes on while the tick runs, unless cpuHalted or a reset request stands
    assign running = wdOn & ~cpuHalted & ~resetReq_q;

    // ****************************************************************
    // Kick synchronisation
    // ****************************************************************
    // Kicks during a pending one merge; age counts whole slow ticks
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            kickPend_q <= 1'b0;
            kickAge_q <= 2'h0;
        end
        else if (kickApply || cpuHalted)
        begin
            kickPend_q <= 1'b0;
            kickAge_q <= 2'h0;
        end
        else if (kickInstruction && !kickPend_q)
        begin
            kickPend_q <= 1'b1;
            kickAge_q <= 2'h0;
        end
        else if (kickPend_q && tickPulse)
        begin
            kickAge_q <= kickAge_q + 2'h1;
        end
    end

    assign kickApply = kickPend_q && tickPulse && (kickAge_q == `WWT_KICK_TICKS - 2'h1);

    // ****************************************************************
    // Counter and window sequencing
    // ****************************************************************
    always @*
    begin
        cnt_d = cnt_q;
        closedPhase_d = closedPhase_q;
        windowLive_d = windowLive_q;
        expire = 1'b0;
        badKick = 1'b0;
        if (!running)
        begin
            cnt_d = 14'h0000;
            closedPhase_d = 1'b0;
            if (cpuHalted || !winOn)
            begin
                windowLive_d = 1'b0;
            end
        end
        else if (winOn && !prevWinOn_q)
        begin
            cnt_d = 14'h0000;
            closedPhase_d = 1'b0;
            windowLive_d = 1'b0;
        end
        else if (kickApply)
        begin
            if (closedPhase_q)
            begin
                badKick = 1'b1;
            end
            else
            begin
                cnt_d = 14'h0000;
                closedPhase_d = winOn;
                windowLive_d = winOn;
            end
        end
        else if (tickPulse)
        begin
            if (closedPhase_q)
            begin
                if (cnt_q == closedLen - 14'h0001)
                begin
                    cnt_d = 14'h0000;
                    closedPhase_d = 1'b0;
                end
                else
                begin
                    cnt_d = cnt_q + 14'h0001;
                end
            end
            else if (cnt_q == openLen - 14'h0001)
            begin
                expire = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 14'h0001;
            end
        end
    end

    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_q <= 14'h0000;
            closedPhase_q <= 1'b0;
            windowLive_q <= 1'b0;
            prevWinOn_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            closedPhase_q <= closedPhase_d;
            windowLive_q <= windowLive_d;
            prevWinOn_q <= winOn & running;
        end
    end

    // ****************************************************************
    // System reset request
    // ****************************************************************
    // A new cause in the acknowledge cycle keeps the request standing
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            resetReq_q <= 1'b0;
        end
        else if (expire || badKick)
        begin
            resetReq_q <= 1'b1;
        end
        else if (sysResetAck)
        begin
            resetReq_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rdData_q <= 8'h00;
        end
        else if (regRdEn && ctrlHit)
        begin
            rdData_q <= ctrl_q;
        end
        else if (regRdEn && stateHit)
        begin
            rdData_q <= {lock_q, 6'h00, pending_q};
        end
        else
        begin
            rdData_q <= 8'h00;
        end
    end

    assign regRdData = rdData_q;
    assign sysResetReq = resetReq_q;
    assign crossingPending = pending_q;
    assign watchdogActive = running;
endmodule

// ==== wwt_watchdog_assertions.sv ====
`timescale 1ns/10ps
// ****
// Port checker
// ****
module wwt_watchdog_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic changeGuardOpen,
    input wire logic cpuHalted,
    input wire logic sysResetReq,
    input wire logic sysResetAck,
    input wire logic crossingPending,
    input wire logic watchdogActive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    rd_idle_a: assert property (
        !$past(regRdEn) |-> regRdData == 8'h00) else $error("read data not idle");
    rd_state_a: assert property (
        $past(regRdEn && regAddr == 8'h01) |-> regRdData[6:0] == {6'h00, $past(crossingPending)})
        else $error("state read wrong");
    req_hold_a: assert property (
        sysResetReq && !sysResetAck |=> sysResetReq) else $error("reset request dropped");
    req_inactive_a: assert property (
        sysResetReq |-> !watchdogActive) else $error("active during request");
    halt_inactive_a: assert property (
        cpuHalted |-> !watchdogActive) else $error("active while halted");
    halt_noreq_a: assert property (
        $rose(sysResetReq) |-> !$past(cpuHalted, 2)) else $error("request while halted");
    pend_cause_a: assert property (
        $rose(crossingPending) |-> $past(regWrEn && regAddr == 8'h00 && changeGuardOpen))
        else $error("pending without guarded write");
    guard_nopend_a: assert property (
        regWrEn && !changeGuardOpen |=> !$rose(crossingPending))
        else $error("unguarded write started crossing");
    pend_clear_a: assert property (
        $rose(crossingPending) |-> ##[1:30] !crossingPending) else $error("pending stuck");
endmodule

bind wwt_watchdog wwt_watchdog_assertions u_chk (.clk_sys, .rst_n, .regAddr, .regWrEn,
    .regRdEn, .regRdData, .changeGuardOpen, .cpuHalted, .sysResetReq, .sysResetAck,
    .crossingPending, .watchdogActive);

// ==== wwt_watchdog_tb.sv ====
`timescale 1ns/10ps
module wwt_watchdog_tb;
    reg clk_sys, rst_n, regWrEn, regRdEn, changeGuardOpen, kickInstruction;
    reg slowTickIn, debugMode, cpuHalted, sysResetAck;
    reg [7:0] regAddr, regWrData, fuseWatchdogCfg, cd;
    reg [31:0] seed, r;
    wire [7:0] regRdData;
    wire sysResetReq, crossingPending, watchdogActive;
    integer miscompares = 0, cmp_count = 0, ticks = 0, cyc = 0, ctl, lck, n, i, c;
    wwt_watchdog dut (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .changeGuardOpen, .fuseWatchdogCfg, .kickInstruction, .slowTickIn,
        .debugMode, .cpuHalted, .sysResetReq, .sysResetAck, .crossingPending, .watchdogActive);
    // ****
    // Clocks
    // ****
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Odd half period keeps the tick unrelated in phase to the clock
    initial
    begin
        slowTickIn = 1'b0;
        forever #403 slowTickIn = ~slowTickIn;
    end
    always @(posedge slowTickIn) ticks = ticks + 1;
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end
    // ****
    // Tasks and model
    // ****
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %s exp %0h got %0h", s, e, g);
        end
    endtask
    task rst(input [7:0] f);
        rst_n <= 1'b0;
        fuseWatchdogCfg <= f;
        ctl = f;
        lck = f[3:0] != 4'h0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task wr(input [7:0] a, input [7:0] d, input g);
        regAddr <= a;
        regWrData <= d;
        changeGuardOpen <= g;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        changeGuardOpen <= 1'b0;
        if (g && a == 8'h00 && lck == 0) ctl = d;
        if (g && a == 8'h01 && (d[7] || debugMode)) lck = d[7];
        @(posedge clk_sys);
        #1;
    endtask
    task rdc(input [7:0] a);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk("read data", a == 8'h00 ? ctl : a == 8'h01 ? {lck[0], 7'h00} : 0, regRdData);
        @(posedge clk_sys);
        #1;
    endtask
    task syncw;
        c = 0;
        while (crossingPending !== 1'b0 && c < 50)
        begin
            @(posedge clk_sys);
            #1;
            c = c + 1;
        end
        chk("pending", 0, crossingPending);
    endtask
    task tw(input integer k);
        repeat (k) @(posedge slowTickIn);
        @(posedge clk_sys);
        #1;
    endtask
    task kick;
        kickInstruction <= 1'b1;
        @(posedge clk_sys);
        kickInstruction <= 1'b0;
        #1;
    endtask
    // Tick count from here to the request; the crossing allows a little slack
    task waitreq(input integer e);
        n = ticks;
        c = 0;
        while (sysResetReq !== 1'b1 && c < 5000)
        begin
            @(posedge clk_sys);
            #1;
            c = c + 1;
        end
        n = ticks - n;
        chk("ticks to reset", e, (n >= e - 1 && n <= e + 2) ? e : n);
        sysResetAck <= 1'b1;
        @(posedge clk_sys);
        sysResetAck <= 1'b0;
        #1;
        chk("request cleared", 0, sysResetReq);
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        seed = 32'h00000033;
        {regWrEn, regRdEn, changeGuardOpen, kickInstruction, debugMode} = 5'h00;
        {cpuHalted, sysResetAck, rst_n} = 3'h0;
        {regAddr, regWrData, fuseWatchdogCfg} = 24'h000000;
        rst(8'h00);
        rdc(8'h00);
        rdc(8'h01);
        rdc(8'h05);
        chk("active", 0, watchdogActive);
        r = rnd();
        wr(8'h00, r[7:0], 1'b0);
        rdc(8'h00);
        $display("test registers done");
        for (i = 0; i < 3; i = i + 1)
        begin
            r = rnd();
            cd = {6'h00, r[1:0]} + 8'h01;
            wr(8'h00, cd, 1'b1);
            syncw;
            chk("active", 1, watchdogActive);
            waitreq(8 << (cd - 1));
        end
        wr(8'h00, 8'h02, 1'b1);
        syncw;
        tw(6);
        kick;
        waitreq(18);
        wr(8'h00, 8'h0C, 1'b1);
        syncw;
        chk("active", 0, watchdogActive);
        $display("test normal mode done");
        wr(8'h00, 8'h11, 1'b1);
        syncw;
        tw(4);
        kick;
        tw(9);
        kick;
        waitreq(18);
        wr(8'h00, 8'h01, 1'b1);
        syncw;
        wr(8'h00, 8'h11, 1'b1);
        syncw;
        tw(2);
        kick;
        tw(3);
        kick;
        waitreq(2);
        $display("test window mode done");
        wr(8'h01, 8'h80, 1'b1);
        rdc(8'h01);
        wr(8'h00, 8'h03, 1'b1);
        rdc(8'h00);
        wr(8'h01, 8'h00, 1'b1);
        rdc(8'h01);
        debugMode <= 1'b1;
        wr(8'h01, 8'h00, 1'b1);
        debugMode <= 1'b0;
        rdc(8'h01);
        $display("test lock done");
        rst(8'h00);
        wr(8'h00, 8'h01, 1'b1);
        syncw;
        tw(5);
        cpuHalted <= 1'b1;
        tw(20);
        chk("halt request", 0, sysResetReq);
        cpuHalted <= 1'b0;
        waitreq(8);
        wr(8'h00, 8'h11, 1'b1);
        syncw;
        kick;
        tw(3);
        cpuHalted <= 1'b1;
        tw(5);
        cpuHalted <= 1'b0;
        waitreq(8);
        rst(8'h21);
        rdc(8'h00);
        rdc(8'h01);
        chk("active", 1, watchdogActive);
        waitreq(8);
        $display("test halt and fuse done");
        end_sim;
    end
endmodule
